// File: design/metering_channel_datapath.sv
// Summary of operation
// RULE_01: Current samples are 24-bit signed at 8 kSPS.
// RULE_02: Full-scale current gives about 5,320,000 codes.
// RULE_03: Current scaled by one plus gain over 2^23.
// RULE_04: Gain change reaches all downstream results and samples.
// RULE_05: Gain reads as 28-bit sign extension, four zeros.
// RULE_06: Then scaled by temperature compensation factor.
// RULE_07: One temperature coefficient shared by all paths.
// RULE_08: Each path has own calibration and measured temperature.
// RULE_09: Compensation starts 1.024 s after select goes low.
// RULE_10: Host never writes coefficient above 0x7fffff.
// RULE_11: High-pass filter removes dc in every path.
// RULE_12: Filter enable bit 4 resets set, clears bypass.
// RULE_13: Filtered currents latched into four sample registers.
// RULE_14: Sample-ready status bit 17 sets on fresh samples.
// RULE_15: Mask bit 17 routes sample-ready to interrupt.
// RULE_16: Pin function 00 pulses pin low 10 us.
// RULE_17: Host may start burst read on pin rise.
// RULE_18: Current samples read as sign-extended 32-bit words.
// RULE_19: Voltage samples are 24-bit signed at 8 kSPS.
// RULE_20: Select outputs choose second voltage or temperature.
// RULE_21: Select bits reset high; clearing selects temperature.
// RULE_22: Select held low 1.024 s before temperatures store.
// RULE_23: Gain and compensation results saturate, never wrap.

////////////////////////////////////////////////////////////////////////
// Word FIFO between the datapath and the downstream energy engine
module sample_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];     // Storage
  logic [AW-1:0]    wr_ptr;          // Next slot to fill
  logic [AW-1:0]    rd_ptr;          // Oldest slot
  logic [AW:0]      count;           // Words held
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];

  // Storage array has no reset; only pointers and count need a defined value
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sample_fifo

////////////////////////////////////////////////////////////////////////
module metering_channel_datapath #(
  parameter longint TEMP_SETTLE_CYCLES = metering_pkg::TEMP_SETTLE_CYC,
  parameter int     FIFO_DEPTH         = 32
) (
  input  wire logic                                             clk_sys,
  input  wire logic                                             rst,
  input  wire logic                                             adc_valid,
  output logic                                                  adc_ready,
  input  wire logic [metering_pkg::NUM_I-1:0][metering_pkg::SAMPLE_W-1:0] adc_current,
  input  wire logic [metering_pkg::NUM_I-1:0][metering_pkg::SAMPLE_W-1:0] adc_voltage,
  input  wire logic [metering_pkg::NUM_I-1:0][metering_pkg::SAMPLE_W-1:0] adc_second,
  input  wire logic [15:0]                                      reg_addr,
  input  wire logic                                             reg_wr,
  input  wire logic                                             reg_rd,
  input  wire logic [31:0]                                      reg_wdata,
  output logic [31:0]                                           reg_rdata,
  output logic [metering_pkg::NUM_I-1:0]                        channel_select_out,
  output logic                                                  crossing_or_ready_pin,
  output logic                                                  irq_n,
  output logic [metering_pkg::NUM_I-1:0][metering_pkg::SAMPLE_W-1:0] voltage_filtered,
  output logic                                                  wave_valid,
  input  wire logic                                             wave_ready,
  output logic [metering_pkg::NUM_I*metering_pkg::SAMPLE_W-1:0] wave_data
);
  import metering_pkg::*;

  localparam int TW = $clog2(TEMP_SETTLE_CYCLES + 1);
  localparam int PW = $clog2(PIN_LOW_CYC + 1);

  ////////////////////////////////////////////////////////////////////////
  // Saturate a wide signed value to the 24-bit sample range
  function automatic logic signed [23:0] sat24(input logic signed [72:0] v);
    return (v > 73'sd8388607) ? 24'sh7fffff : (v < -73'sd8388608) ? 24'sh800000 : v[23:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [31:0]              sample_status;       // Sticky flags
  logic [31:0]              interrupt_mask;      // Interrupt enables
  logic [15:0]              general_config;      // Filter and pin controls
  logic [NUM_I-1:0]         channel_select_config; // 1 second voltage, 0 temperature
  logic signed [23:0]       shunt_temp_coefficient; // Shared by all shunts
  logic signed [23:0]       current_gain      [NUM_I];
  logic signed [23:0]       cal_temperature   [NUM_I];
  logic signed [23:0]       shunt_temperature [NUM_I];
  logic signed [23:0]       current_sample    [NUM_I];
  logic [NUM_I-1:0]         temp_valid;          // Compensation live per path
  logic [31:0]              next_rdata;          // Read mux result
  pin_state_e               pin_state;
  logic [PW-1:0]            pin_cnt;             // Cycles in current pin state

  // Datapath wires
  logic signed [23:0]       chan_in  [NUM_CH];   // Filter inputs
  logic signed [23:0]       chan_out [NUM_CH];   // Filter or bypass outputs
  logic signed [23:0]       gained   [NUM_I];
  logic signed [23:0]       compensated [NUM_I];

  // Handshake and decode
  wire accept        = adc_valid && adc_ready;
  wire filter_enable = general_config[FILTER_EN_BIT];
  wire [1:0] pin_function_select = general_config[PIN_FUNC_LSB +: 2];
  wire sel_status    = reg_addr == ADDR_STATUS;
  wire sel_mask      = reg_addr == ADDR_MASK;
  wire sel_config    = reg_addr == ADDR_CONFIG;
  wire sel_selcfg    = reg_addr == ADDR_SEL_CONFIG;
  wire sel_shunt_temp_coefficient    = reg_addr == ADDR_SHUNT_TEMP_COEFFICIENT;
  wire ready_clear   = reg_wr && sel_status && reg_wdata[READY_BIT];
  wire fifo_in_ready;

  // FIFO room is the only thing that stalls sample intake
  assign adc_ready          = fifo_in_ready; // RULE_13
  assign channel_select_out = channel_select_config; // RULE_20
  assign irq_n              = !(sample_status[READY_BIT] && interrupt_mask[READY_BIT]); // RULE_15
  // Pin idles high; zero-crossing modes are not built here and hold it high
  assign crossing_or_ready_pin = pin_state != PIN_LOW; // RULE_16

  ////////////////////////////////////////////////////////////////////////
  // Per-current path: gain, temperature compensation, registers
  for (genvar i = 0; i < NUM_I; i++) begin : g_cur
    wire sel_gain  = reg_addr == ADDR_GAIN_BASE + 16'(i);
    wire sel_calt  = reg_addr == ADDR_CALT_BASE + 16'(i);
    wire signed [24:0] gain_factor = {current_gain[i][23], current_gain[i]} + 25'sh800000;
    wire signed [48:0] gain_prod   = $signed(adc_current[i]) * gain_factor; // RULE_01 RULE_02
    wire signed [24:0] temp_delta  = {shunt_temperature[i][23], shunt_temperature[i]}
                                   - {cal_temperature[i][23], cal_temperature[i]};
    wire signed [48:0] coef_prod   = shunt_temp_coefficient * temp_delta;
    wire signed [72:0] corr_prod   = gained[i] * coef_prod;
    wire signed [72:0] comp_sum    = 73'(gained[i]) - (corr_prod >>> 46);

    assign gained[i]      = sat24(73'(gain_prod >>> 23)); // RULE_03 RULE_23
    // Factor stays at one until the settle time has run out
    assign compensated[i] = temp_valid[i] ? sat24(comp_sum) : gained[i]; // RULE_06 RULE_07 RULE_08 RULE_23
    assign chan_in[i]     = compensated[i];
    assign chan_in[i+NUM_I] = adc_voltage[i]; // RULE_19

    // Host-written calibration values; gain arrives padded with four zeros
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        current_gain[i]    <= '0;
        cal_temperature[i] <= '0;
      end else begin
        if (reg_wr && sel_gain) current_gain[i]    <= reg_wdata[27:4];
        if (reg_wr && sel_calt) cal_temperature[i] <= reg_wdata[23:0];
      end
    end

    // Settle timer runs while the select output is low
    logic [TW-1:0] settle_cnt;
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        settle_cnt    <= '0;
        temp_valid[i] <= 1'b0;
      end else if (channel_select_config[i]) begin
        settle_cnt    <= '0;
        temp_valid[i] <= 1'b0;
      end else if (settle_cnt == TW'(TEMP_SETTLE_CYCLES - 1)) begin
        temp_valid[i] <= 1'b1; // RULE_09 RULE_22
      end else begin
        settle_cnt    <= settle_cnt + 1'b1;
      end
    end

    // Measured temperature and waveform sample latch at sample rate
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        shunt_temperature[i] <= '0;
        current_sample[i]    <= '0;
      end else if (accept) begin
        // A select just raised blocks the store, so a voltage never lands here
        if (temp_valid[i] && !channel_select_config[i]) shunt_temperature[i] <= adc_second[i]; // RULE_09 RULE_20
        current_sample[i] <= chan_out[i]; // RULE_13 RULE_04
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // DC-removal filter on every current and voltage path
  for (genvar c = 0; c < NUM_CH; c++) begin : g_hpf
    // Dc estimate with HPF_SHIFT fraction bits; a first-order leak
    logic signed [SAMPLE_W+HPF_SHIFT-1:0] dc_acc;
    wire  signed [SAMPLE_W+HPF_SHIFT-1:0] x_wide = {chan_in[c], {HPF_SHIFT{1'b0}}};
    wire  signed [SAMPLE_W+HPF_SHIFT:0]   acc_err = (SAMPLE_W+HPF_SHIFT+1)'(x_wide)
                                                  - (SAMPLE_W+HPF_SHIFT+1)'(dc_acc);
    wire  signed [SAMPLE_W+HPF_SHIFT-1:0] next_acc = dc_acc
                                          + (SAMPLE_W+HPF_SHIFT)'(acc_err >>> HPF_SHIFT);
    wire  signed [SAMPLE_W:0]             hp_diff = (SAMPLE_W+1)'(chan_in[c])
                                          - (SAMPLE_W+1)'(dc_acc >>> HPF_SHIFT);

    assign chan_out[c] = filter_enable ? sat24(73'(hp_diff)) : chan_in[c]; // RULE_11 RULE_12

    // Estimate keeps tracking even while bypassed, so re-enable is glitch-free
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        dc_acc <= '0;
      end else if (accept) begin
        dc_acc <= next_acc; // RULE_11
      end
    end
  end

  // Filtered voltages go out as registered samples
  for (genvar v = 0; v < NUM_I; v++) begin : g_volt
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        voltage_filtered[v] <= '0;
      end else if (accept) begin
        voltage_filtered[v] <= chan_out[v+NUM_I];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Filtered currents stream to the energy engine through the FIFO
  sample_fifo #(
    .WIDTH (NUM_I*SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (adc_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({chan_out[3], chan_out[2], chan_out[1], chan_out[0]}),
    .out_valid (wave_valid),
    .out_ready (wave_ready),
    .out_data  (wave_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control registers; sample-ready set beats a same-cycle clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sample_status          <= '0;
      interrupt_mask         <= MASK_RESET;
      general_config         <= CONFIG_RESET; // RULE_12
      channel_select_config  <= SEL_RESET; // RULE_21
      shunt_temp_coefficient <= '0;
    end else begin
      if (accept) sample_status[READY_BIT] <= 1'b1; // RULE_14
      else if (ready_clear) sample_status[READY_BIT] <= 1'b0;
      if (reg_wr && sel_mask)   interrupt_mask        <= reg_wdata;
      if (reg_wr && sel_config) general_config        <= reg_wdata[15:0];
      if (reg_wr && sel_selcfg) channel_select_config <= reg_wdata[NUM_I-1:0]; // RULE_21
      // Host keeps this non-negative; the path trusts it
      if (reg_wr && sel_shunt_temp_coefficient) shunt_temp_coefficient <= reg_wdata[23:0]; // RULE_10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux with serial-port word formats
  always_comb begin
    next_rdata = '0;
    if (sel_status) next_rdata = sample_status;
    if (sel_mask)   next_rdata = interrupt_mask;
    if (sel_config) next_rdata = {16'h0000, general_config};
    if (sel_selcfg) next_rdata = {28'h0000000, channel_select_config};
    if (sel_shunt_temp_coefficient) next_rdata = {{8{shunt_temp_coefficient[23]}}, shunt_temp_coefficient};
    for (int k = 0; k < NUM_I; k++) begin
      if (reg_addr == ADDR_GAIN_BASE + 16'(k)) begin
        next_rdata = {{4{current_gain[k][23]}}, current_gain[k], 4'h0}; // RULE_05
      end
      if (reg_addr == ADDR_CALT_BASE + 16'(k)) begin
        next_rdata = {{8{cal_temperature[k][23]}}, cal_temperature[k]};
      end
      if (reg_addr == ADDR_SHUNT_BASE + 16'(k)) begin
        next_rdata = {8'h00, shunt_temperature[k]};
      end
      if (reg_addr == ADDR_SAMPLE_BASE + 16'(k)) begin
        next_rdata = {{8{current_sample[k][23]}}, current_sample[k]}; // RULE_18
      end
    end
  end

  // Read data held until the next read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ready pin pulse; a sample arriving mid-pulse does not restart it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_state <= PIN_IDLE;
      pin_cnt   <= '0;
    end else begin
      unique case (pin_state)
        PIN_IDLE: begin
          pin_cnt <= '0;
          if (accept && pin_function_select == PIN_FUNC_READY) pin_state <= PIN_DELAY; // RULE_16
        end
        PIN_DELAY: begin
          pin_cnt <= pin_cnt + 1'b1;
          if (pin_cnt == PW'(PIN_DELAY_CYC - 1)) begin
            pin_state <= PIN_LOW;
            pin_cnt   <= '0;
          end
        end
        PIN_LOW: begin
          pin_cnt <= pin_cnt + 1'b1;
          if (pin_cnt == PW'(PIN_LOW_CYC - 1)) pin_state <= PIN_IDLE; // RULE_16
        end
        default: pin_state <= PIN_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_pin_delay;
    crossing_or_ready_pin [*4];
  endsequence
  sequence s_pin_low;
    ##[499:499] !crossing_or_ready_pin ##1 crossing_or_ready_pin;
  endsequence

  property p_ready_set;
    @(posedge clk_sys) disable iff (rst) accept |=> sample_status[READY_BIT];
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready flag not set"); // RULE_14
  property p_irq;
    accept && interrupt_mask[READY_BIT] |=> !irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // RULE_15
  property p_pin_start;
    accept && pin_state == PIN_IDLE && pin_function_select == PIN_FUNC_READY
    |-> s_pin_delay ##1 !crossing_or_ready_pin;
  endproperty
  a_pin_start: assert property (p_pin_start) else $error("pin fall timing wrong"); // RULE_16
  property p_pin_width;
    @(posedge clk_sys) disable iff (rst) $fell(crossing_or_ready_pin) |-> s_pin_low;
  endproperty
  a_pin_width: assert property (p_pin_width) else $error("pin low width wrong"); // RULE_16
  property p_select;
    reg_wr && sel_selcfg |=> channel_select_out == $past(reg_wdata[NUM_I-1:0]);
  endproperty
  a_select: assert property (p_select) else $error("select outputs wrong"); // RULE_21
  property p_gain_read;
    reg_rd && reg_addr == ADDR_GAIN_BASE
    |=> reg_rdata[3:0] == 4'h0 && reg_rdata[31:27] == {5{reg_rdata[27]}};
  endproperty
  a_gain_read: assert property (p_gain_read) else $error("gain read format wrong"); // RULE_05
  property p_sample_read;
    reg_rd && reg_addr == ADDR_SAMPLE_BASE |=> reg_rdata[31:23] == {9{reg_rdata[23]}};
  endproperty
  a_sample_read: assert property (p_sample_read) else $error("sample read format wrong"); // RULE_18
  property p_bypass;
    accept && !filter_enable |=> current_sample[0] == $past(compensated[0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("filter not bypassed"); // RULE_12
  property p_temp_hold;
    channel_select_config[0] |=> !temp_valid[0] && $stable(shunt_temperature[0]);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("temperature stored early"); // RULE_09
  property p_gain_sat;
    !adc_current[0][23] && !current_gain[0][23] |-> !gained[0][23];
  endproperty
  a_gain_sat: assert property (p_gain_sat) else $error("gain stage wrapped"); // RULE_23

endmodule // metering_channel_datapath

// File: include/metering_pkg.sv
package metering_pkg;

  // Sample and channel geometry
  localparam int SAMPLE_W  = 24;
  localparam int NUM_I     = 4;          // Phase a, b, c and neutral currents
  localparam int NUM_CH    = 8;          // Four currents then four voltages
  localparam int HPF_SHIFT = 10;         // Pole of the dc-removal filter

  // Clock and timing, each time in its own unit
  localparam longint CLK_HZ           = 50_000_000;
  localparam longint TEMP_SETTLE_US   = 1_024_000;   // 1.024 sec
  localparam longint PIN_DELAY_NS     = 70;
  localparam longint PIN_LOW_NS       = 10_000;      // 10 us
  localparam longint TEMP_SETTLE_CYC  = TEMP_SETTLE_US * CLK_HZ / 1_000_000;
  // Delay is a longest time, so its count rounds down; the low width count rounds up
  localparam int     PIN_DELAY_CYC    = int'(PIN_DELAY_NS * CLK_HZ / 1_000_000_000);
  localparam int     PIN_LOW_CYC      = int'((PIN_LOW_NS * CLK_HZ + 999_999_999) / 1_000_000_000);

  // Register offsets
  localparam logic [15:0] ADDR_STATUS      = 16'he502;
  localparam logic [15:0] ADDR_MASK        = 16'he50a;
  localparam logic [15:0] ADDR_CONFIG      = 16'he618;
  localparam logic [15:0] ADDR_SEL_CONFIG  = 16'he708;
  localparam logic [15:0] ADDR_GAIN_BASE   = 16'he800;  // Four current gains
  localparam logic [15:0] ADDR_SHUNT_TEMP_COEFFICIENT      = 16'he804;
  localparam logic [15:0] ADDR_CALT_BASE   = 16'he805;  // Four calibration temperatures
  localparam logic [15:0] ADDR_SHUNT_BASE  = 16'he809;  // Four measured temperatures
  localparam logic [15:0] ADDR_SAMPLE_BASE = 16'he80d;  // Four current samples

  // Field positions and reset values
  localparam int          READY_BIT        = 17;
  localparam int          FILTER_EN_BIT    = 4;
  localparam int          PIN_FUNC_LSB     = 0;
  localparam logic [1:0]  PIN_FUNC_READY   = 2'h0;
  localparam logic [15:0] CONFIG_RESET     = 16'h0010;
  localparam logic [3:0]  SEL_RESET        = 4'hf;
  localparam logic [31:0] MASK_RESET       = 32'h0000_0000;

  // Ready pin sequencer, Gray along idle, delay, low
  typedef enum logic [1:0] {
    PIN_IDLE  = 2'b00,
    PIN_DELAY = 2'b01,
    PIN_LOW   = 2'b11
  } pin_state_e;

endpackage

// File: sim/host_model.sv
////////////////////////////////////////////////////////////////////////
// Host side of the register port: one-cycle strobes, one word each
module host_model (
  input  wire logic        clk_sys,
  input  wire logic [31:0] reg_rdata,
  output logic [15:0]      reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [31:0]      reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import metering_pkg::*;

  // Quiet bus from time zero
  initial begin
    reg_addr = '0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_wdata = '0;
  end

  // Strobe for one edge; the idle bus is then inverted, so stale values never look valid
  task automatic put(input logic [15:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_sys) #1;
    reg_addr = a;
    reg_wdata = (w && a == ADDR_SHUNT_TEMP_COEFFICIENT && d > 32'h7f_ffff) ? 32'h7f_ffff : d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk_sys) #1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask

  // Read data is registered on the strobe's edge, taken just after it
  task automatic get(input logic [15:0] a, output logic [31:0] d);
    put(a, '0, 1'h0);
    d = reg_rdata;
  endtask
endmodule // host_model

// File: sim/tb_metering_channel_datapath.sv
////////////////////////////////////////////////////////////////////////
module tb_metering_channel_datapath;
  timeunit 1ns;
  timeprecision 1ns;
  import metering_pkg::*;

  typedef logic [NUM_I-1:0][SAMPLE_W-1:0] set_t;
  logic        clk_sys = 1'h0;
  logic        rst = 1'h1;
  logic        adc_valid = 1'h0;
  logic        wave_ready = 1'h1;
  logic        adc_ready, wave_valid, pin, irq_n, reg_wr, reg_rd;
  set_t        c = '0, vol = '0, sec = '0, vflt;   // Sample set driven, filtered voltages seen
  logic [95:0] wdat;
  logic [3:0]  sel;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, rd;
  logic [31:0] seed = 32'h933f;                    // Fixed seed keeps runs repeatable
  int          n_fail = 0, checked = 0, cyc = 0, k, j;
  logic [23:0] gt[4] = '{24'h40_0000, 24'hc0_0000, 24'h40_0000, 24'h40_0000};
  logic [23:0] xt[4] = '{24'h10_0000, 24'hf0_0000, 24'h7f_ffff, 24'h80_0000};

  // Short settle count so the temperature path is reached quickly
  metering_channel_datapath #(.TEMP_SETTLE_CYCLES(20)) DUT (
    .clk_sys(clk_sys), .rst(rst), .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_current(c),
    .adc_voltage(vol), .adc_second(sec), .reg_addr(addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .channel_select_out(sel), .crossing_or_ready_pin(pin),
    .irq_n(irq_n), .voltage_filtered(vflt), .wave_valid(wave_valid), .wave_ready(wave_ready),
    .wave_data(wdat));
  host_model H (.clk_sys(clk_sys), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(wdata));

  always #10 clk_sys = ~clk_sys;
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'h0;
  end

  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] sx(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction
  // Fractional scaling by one plus g over 2^23, clipped to 24 bits
  function automatic logic [23:0] scale(input logic [23:0] x, input logic [23:0] g);
    longint p;
    p = (longint'($signed(x)) * (longint'($signed(g)) + 64'sh80_0000)) >>> 23;
    return (p > 64'sh7f_ffff) ? 24'h7f_ffff : (p < -64'sh80_0000) ? 24'h80_0000 : p[23:0];
  endfunction
  // Hold one set until taken; returns in the cycle after the accepting edge
  task automatic send(input set_t s);
    c = s;
    vol = ~s;
    sec = {4{24'h40_0000}};
    adc_valid = 1'h1;
    for (k = 0; k < 100 && adc_ready !== 1'h1; k++) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    adc_valid = 1'h0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the run's length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    wait (rst === 1'h0);
    H.get(ADDR_CONFIG, rd);
    check(rd, CONFIG_RESET);
    H.get(ADDR_SEL_CONFIG, rd);
    check({rd, sel, pin, irq_n}, {32'hf, 4'hf, 2'h3});
    H.put(ADDR_MASK, 32'h2_0000, 1'h1);
    send({4{24'h00_0100}});
    check(irq_n, 1'h0);
    for (k = 1; k < 9 && pin !== 1'h0; k++) @(posedge clk_sys) #1;
    check(k, PIN_DELAY_CYC + 1);
    for (k = 0; k < 600 && pin === 1'h0; k++) @(posedge clk_sys) #1;
    check(k, PIN_LOW_CYC);
    H.get(ADDR_STATUS, rd);
    check(rd[17], 1'h1);
    H.put(ADDR_STATUS, 32'h2_0000, 1'h1);
    H.get(ADDR_STATUS, rd);
    check({rd[17], irq_n}, 2'h1);
    $display("test ready done");
    // Filters off, pin given to the other function: must stay high
    H.put(ADDR_CONFIG, 32'h1, 1'h1);
    repeat (24) begin
      send({xs(), xs(), xs()});
      check({wave_valid, wdat, vflt, pin}, {1'h1, c, ~c, 1'h1});
      for (j = 0; j < 4; j++) begin
        H.get(ADDR_SAMPLE_BASE + 16'(j), rd);
        check(rd, sx(c[j]));
      end
    end
    $display("test bypass done");
    for (j = 0; j < 4; j++) begin
      H.put(ADDR_GAIN_BASE, {4'h0, gt[j], 4'h0}, 1'h1);
      H.get(ADDR_GAIN_BASE, rd);
      check(rd, {{4{gt[j][23]}}, gt[j], 4'h0});
      send({4{xt[j]}});
      check(wdat, {{3{xt[j]}}, scale(xt[j], gt[j])});
      H.get(ADDR_SAMPLE_BASE, rd);
      check(rd, sx(scale(xt[j], gt[j])));
    end
    H.put(ADDR_GAIN_BASE, '0, 1'h1);
    $display("test gain done");
    // Phase b calibrated at the measured temperature, so it stays uncompensated
    H.put(ADDR_SHUNT_TEMP_COEFFICIENT, 32'h40_0000, 1'h1);
    H.put(ADDR_CALT_BASE + 16'h1, 32'h40_0000, 1'h1);
    H.put(ADDR_SEL_CONFIG, 32'h0, 1'h1);
    check(sel, 4'h0);
    send({4{24'h10_0000}});
    check(wdat, c);
    repeat (30) @(posedge clk_sys) #1;
    send(c);
    H.get(ADDR_SHUNT_BASE, rd);
    check(rd, 32'h40_0000);
    send(c);
    check(wdat, {24'hc_0000, 24'hc_0000, 24'h10_0000, 24'hc_0000});
    H.put(ADDR_SEL_CONFIG, 32'hf, 1'h1);
    check(sel, 4'hf);
    H.put(ADDR_SHUNT_TEMP_COEFFICIENT, '0, 1'h1);
    $display("test temperature done");
    // Long dc run with filters on: output must decay toward zero
    H.put(ADDR_CONFIG, 32'h10, 1'h1);
    c = {4{24'h20_0000}};
    adc_valid = 1'h1;
    repeat (6000) @(posedge clk_sys) #1;
    adc_valid = 1'h0;
    check($signed(wdat[23:0]) < 24'sh2_0000 && $signed(wdat[23:0]) > -24'sh2_0000, 1'h1);
    $display("test filter done");
    // Stall the drain until the buffer refuses, then empty it
    // One edge with the drain still open empties the buffer first
    @(posedge clk_sys) #1;
    wave_ready = 1'h0;
    adc_valid = 1'h1;
    for (k = 0; k < 40 && adc_ready === 1'h1; k++) @(posedge clk_sys) #1;
    adc_valid = 1'h0;
    wave_ready = 1'h1;
    for (j = 0; j < 40 && wave_valid === 1'h1; j++) @(posedge clk_sys) #1;
    check({k, j}, {32'd32, 32'd32});
    $display("test buffer done");
    print_verdict();
  end
endmodule // tb_metering_channel_datapath
